/* File: bench/ctrl_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Data bus as the controller sees it; a released bus shows the inverse of its last value,
// so a stale read can never pass for a good one
module ctrl_bus_model (
    input wire logic core_clk,
    input wire logic [31:0] data_out,
    input wire logic data_oe,
    output logic [31:0] bus_view
);
    logic [31:0] last_reg = 32'h0;
    always_ff @(posedge core_clk) begin
        if (data_oe) begin
            last_reg <= data_out;
        end
    end
    assign bus_view = data_oe ? data_out : ~last_reg;
endmodule : ctrl_bus_model

`default_nettype wire

/* File: bench/tb_flowthrough_burst_sram_port.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_flowthrough_burst_sram_port;
    logic core_clk = 0, reset_n = 0, clk_gate_n = 0, sel_primary_n = 1, sel_secondary_hi = 0;
    logic sel_tertiary_n = 1, step_or_load = 1, rd_wr_sel = 1, out_enable_n = 0;
    logic burst_order_sel = 1, sleep_request = 0, data_oe, sleep_active;
    logic [5:0] addr = 6'h00;
    logic [3:0] lane_write_strobe_n = 4'hf;
    logic [31:0] data_in = 32'h0, data_out, bus_view, pat;
    logic [31:0] mem [64];
    logic [2:0] desel [3] = '{3'b110, 3'b000, 3'b011};
    int failures = 0, checks_done = 0;
    always #20 core_clk = ~core_clk;
    flowthrough_burst_sram_port #(.ADDR_W(6)) i_flowthrough_burst_sram_port (
        .core_clk(core_clk), .reset_n(reset_n), .clk_gate_n(clk_gate_n),
        .sel_primary_n(sel_primary_n), .sel_secondary_hi(sel_secondary_hi),
        .sel_tertiary_n(sel_tertiary_n), .step_or_load(step_or_load), .rd_wr_sel(rd_wr_sel),
        .addr(addr), .lane_write_strobe_n(lane_write_strobe_n), .out_enable_n(out_enable_n),
        .burst_order_sel(burst_order_sel), .sleep_request(sleep_request), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .sleep_active(sleep_active));
    ctrl_bus_model i_ctrl_bus_model (.core_clk(core_clk), .data_out(data_out),
        .data_oe(data_oe), .bus_view(bus_view));
    task automatic cmp1(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : cmp1
    task automatic cmp32(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : cmp32
    task automatic report_and_stop;
        $display("Checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    // One bus cycle; selects given as {primary_n, secondary_hi, tertiary_n}
    task automatic drv(input logic st, input logic [2:0] sel, input logic rw,
                       input logic [5:0] a, input logic [3:0] bw, input logic [31:0] d,
                       input logic g);
        @(posedge core_clk);
        step_or_load <= st;
        {sel_primary_n, sel_secondary_hi, sel_tertiary_n} <= sel;
        rd_wr_sel <= rw;
        addr <= a;
        lane_write_strobe_n <= bw;
        data_in <= d;
        clk_gate_n <= g;
    endtask : drv
    function automatic logic [5:0] ea(input logic [5:0] a, input int k);
        return {a[5:2], burst_order_sel ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
    endfunction : ea
    task automatic chk(input logic rw, input logic [5:0] a, input int k);
        #1;
        cmp1("data_oe", rw & !out_enable_n, data_oe);
        if (rw & !out_enable_n) cmp32("data", mem[ea(a, k)], bus_view);
    endtask : chk
    // Four-beat burst; advance cycles carry junk address and inverted direction on purpose
    task automatic burst(input logic rw, input logic [5:0] a, input logic [3:0] bw,
                         input logic st);
        logic [31:0] d;
        drv(1'b0, 3'b010, rw, a, bw, 32'h0, 1'b0);
        for (int k = 0; k < 4; k++) begin
            d = {4{ea(a, k), 2'(k)}} ^ pat;
            if (st && k == 2) begin
                drv(1'b1, 3'b111, ~rw, ~a, bw, d, 1'b1);
                chk(rw, a, k);
            end
            drv(k < 3, 3'b111, ~rw, ~a, bw, d, 1'b0);
            chk(rw, a, k);
            for (int l = 0; l < 4; l++) begin
                if (!rw && !bw[l]) mem[ea(a, k)][8*l+:8] = d[8*l+:8];
            end
        end
        drv(1'b1, 3'b111, 1'b1, a, 4'hf, 32'h0, 1'b0);
        chk(1'b0, a, 0);
    endtask : burst
    initial begin
        #40000;
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        #1;
        cmp1("data_oe", 1'b0, data_oe);
        cmp1("sleep_active", 1'b0, sleep_active);
        pat = 32'h3c00a500;
        burst(1'b0, 6'h05, 4'h0, 1'b0);
        burst(1'b1, 6'h05, 4'hf, 1'b1);
        $display("Test interleaved done");
        @(posedge core_clk);
        burst_order_sel <= 1'b0;
        pat = 32'h5a5a0f0f;
        burst(1'b0, 6'h07, 4'ha, 1'b1);
        burst(1'b1, 6'h06, 4'hf, 1'b0);
        burst(1'b0, 6'h04, 4'hf, 1'b0);
        burst(1'b1, 6'h04, 4'hf, 1'b1);
        // Five beats: the fifth must come back to the start address
        drv(1'b0, 3'b010, 1'b1, 6'h06, 4'hf, 32'h0, 1'b0);
        for (int k = 0; k < 5; k++) begin
            drv(1'b1, 3'b111, 1'b0, 6'h00, 4'hf, 32'h0, 1'b0);
            chk(1'b1, 6'h06, k);
        end
        $display("Test linear done");
        @(posedge core_clk);
        out_enable_n <= 1'b1;
        burst(1'b1, 6'h05, 4'hf, 1'b0);
        @(posedge core_clk);
        out_enable_n <= 1'b0;
        foreach (desel[i]) begin
            drv(1'b0, desel[i], 1'b1, 6'h04, 4'hf, 32'h0, 1'b0);
            drv(1'b1, 3'b010, 1'b1, 6'h05, 4'hf, 32'h0, 1'b0);
            chk(1'b0, 6'h04, 0);
        end
        $display("Test deselect done");
        @(posedge core_clk);
        sleep_request <= 1'b1;
        drv(1'b0, 3'b010, 1'b0, 6'h04, 4'h0, 32'h0, 1'b0);
        drv(1'b1, 3'b111, 1'b1, 6'h00, 4'h0, 32'hffffffff, 1'b0);
        drv(1'b1, 3'b111, 1'b1, 6'h00, 4'hf, 32'h0, 1'b0);
        #1;
        cmp1("sleep_active", 1'b1, sleep_active);
        cmp1("data_oe", 1'b0, data_oe);
        @(posedge core_clk);
        sleep_request <= 1'b0;
        drv(1'b1, 3'b111, 1'b1, 6'h00, 4'hf, 32'h0, 1'b0);
        #1;
        cmp1("sleep_active", 1'b0, sleep_active);
        burst(1'b1, 6'h04, 4'hf, 1'b0);
        $display("Test sleep done");
        report_and_stop();
    end
endmodule : tb_flowthrough_burst_sram_port

`default_nettype wire

/* File: rtl/flowthrough_burst_sram_port.sv */
// What this block does
// [RULE_01] All inputs clocked except output enable, burst order select and sleep request.
// [RULE_02] Clock gate high freezes every state element and stalls bursts. Sleep request still clears state and updates sleep_active while gated.
// [RULE_03] External address captured only on a load with all three selects active.
// [RULE_04] Selects looked at only in load cycles, ignored while stepping.
// [RULE_05] Step high advances the burst counter; step low loads a new address.
// [RULE_06] Load with read/write high starts a read, low starts a write.
// [RULE_07] Four active-low lane strobes, sampled on write command and each write beat.
// [RULE_08] Data driven only when selected read and output enable active, released combinationally.
// [RULE_09] Burst order select high or open means interleaved, low means linear.
// [RULE_10] Interleaved order: low bits are start XOR beat count.
// [RULE_11] Linear order: low bits are start plus beat count modulo four.
// [RULE_12] Sleep request high enters low-power sleep, memory contents kept.
// [RULE_13] In sleep the port is deselected, ignores inputs, releases all outputs.
// [RULE_14] Sleep lasts exactly while sleep request is high.
// [RULE_15] Controller finishes all pending operations before raising sleep request.
// [RULE_16] After sleep exit the controller issues only deselect or read cycles.
// [RULE_17] Write data arrive one cycle after the write command and address.
// [RULE_18] Any inactive select on a load deselects and floats the data bus.
// [RULE_19] Burst counter is two bits and wraps every fourth beat.
// [RULE_20] Masked cycle writes nothing, keeps read drive or write float.
// [RULE_21] Upper address bits fixed for the burst, only low two bits sequence.
`timescale 1ns/1ps
`default_nettype none
`include "sram_port_regs.svh"

module flowthrough_burst_sram_port
    import sram_port_pkg::*;
#(
    parameter int ADDR_W = `SP_ADDR_W,
    parameter int LANES = `SP_LANES,
    parameter int LANE_W = `SP_LANE_W
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_gate_n,
    input wire logic sel_primary_n,
    input wire logic sel_secondary_hi,
    input wire logic sel_tertiary_n,
    input wire logic step_or_load,
    input wire logic rd_wr_sel,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [LANES-1:0] lane_write_strobe_n,
    input wire logic out_enable_n,
    input wire logic burst_order_sel,
    input wire logic sleep_request,
    input wire logic [LANES*LANE_W-1:0] data_in,
    output logic [LANES*LANE_W-1:0] data_out,
    output logic data_oe,
    output logic sleep_active
);

    localparam int DATA_W = LANES * LANE_W;
    localparam int UP_W = ADDR_W - `SP_BEAT_W;

    // Strobe pins are fixed at four lanes, and the address must be wider than the beat
    if (ADDR_W <= `SP_BEAT_W || LANES != `SP_LANES || LANE_W < 1) begin : g_bad_params
        $error("flowthrough_burst_sram_port: unsupported parameters");
    end

    op_state_type state_reg;
    burst_pos_type pos_reg;
    wr_pend_type wr_pend_reg;
    logic [UP_W-1:0] upper_reg;
    logic [ADDR_W-1:0] wr_addr_reg;
    logic drive_reg;
    logic sleep_active_reg;

    logic edge_en;
    logic load;
    logic selected;
    logic rd_cmd;
    logic wr_cmd;
    logic wr_beat;
    logic [`SP_BEAT_W-1:0] beat_next;
    logic [`SP_BEAT_W-1:0] cur_low;
    logic [`SP_BEAT_W-1:0] step_low;
    logic [ADDR_W-1:0] acc_addr;
    logic [LANES-1:0] mem_be;
    logic mem_we;

    // Sleep request is asynchronous and acts at once, not through a flop
    assign edge_en = ~clk_gate_n & ~sleep_request; // [RULE_01] [RULE_02] [RULE_13] [RULE_14]
    assign load = ~step_or_load; // [RULE_05]
    assign selected = ~sel_primary_n & sel_secondary_hi & ~sel_tertiary_n; // [RULE_04]
    assign rd_cmd = (load & selected & rd_wr_sel) | (~load & (state_reg == ST_READ)); // [RULE_06]
    assign wr_cmd = load & selected & ~rd_wr_sel; // [RULE_06]
    assign wr_beat = wr_cmd | (~load & (state_reg == ST_WRITE));
    assign beat_next = pos_reg.beat + `SP_BEAT_STEP; // [RULE_19]

    // Open strap reads high, so interleaved is the default order
    assign cur_low = burst_order_sel ? (pos_reg.start ^ pos_reg.beat)
                                     : (pos_reg.start + pos_reg.beat); // [RULE_09] [RULE_10] [RULE_11]
    assign step_low = burst_order_sel ? (pos_reg.start ^ beat_next)
                                      : (pos_reg.start + beat_next); // [RULE_10] [RULE_11]
    assign acc_addr = load ? addr : {upper_reg, step_low}; // [RULE_21]

    assign mem_we = edge_en & wr_pend_reg.valid; // [RULE_20]
    assign mem_be = mem_we ? wr_pend_reg.lane_we : '0; // [RULE_07]

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
        end else if (sleep_request) begin
            state_reg <= ST_IDLE; // [RULE_13]
        end else if (edge_en && load) begin
            case ({selected, rd_wr_sel})
                2'b11: state_reg <= ST_READ;
                2'b10: state_reg <= ST_WRITE;
                default: state_reg <= ST_IDLE; // [RULE_18]
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pos_reg <= '{start: `SP_BEAT_RST, beat: `SP_BEAT_RST};
            upper_reg <= '0;
        end else if (edge_en) begin
            if (load && selected) begin
                pos_reg <= '{start: addr[`SP_BEAT_W-1:0], beat: `SP_BEAT_RST}; // [RULE_03]
                upper_reg <= addr[ADDR_W-1:`SP_BEAT_W]; // [RULE_03] [RULE_21]
            end else if (!load) begin
                pos_reg.beat <= beat_next; // [RULE_05] [RULE_19]
            end
        end
    end

    // Late write: command and strobes now, data on the next live edge
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            wr_pend_reg <= '{valid: 1'b0, lane_we: '0};
            wr_addr_reg <= '0;
        end else if (sleep_request) begin
            wr_pend_reg <= '{valid: 1'b0, lane_we: '0};
        end else if (edge_en) begin
            wr_pend_reg.valid <= wr_beat & ~(&lane_write_strobe_n); // [RULE_17]
            wr_pend_reg.lane_we <= ~lane_write_strobe_n; // [RULE_07]
            wr_addr_reg <= acc_addr;
        end
    end

    // Drive is held in a masked cycle, so a read stays on the bus
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            drive_reg <= 1'b0;
        end else if (sleep_request) begin
            drive_reg <= 1'b0; // [RULE_13]
        end else if (edge_en) begin
            drive_reg <= rd_cmd & (~load | selected); // [RULE_18] [RULE_20]
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            sleep_active_reg <= 1'b0;
        end else begin
            sleep_active_reg <= sleep_request; // [RULE_12] [RULE_14]
        end
    end

    // Enable is gated by the asynchronous pins so turn-off needs no edge
    assign data_oe = drive_reg & ~out_enable_n & ~sleep_request; // [RULE_08] [RULE_13]
    assign sleep_active = sleep_active_reg;

    sram_store #(
        .ADDR_W(ADDR_W),
        .LANES(LANES),
        .LANE_W(LANE_W)
    ) u_store (
        .clk(core_clk),
        .rd_en(edge_en & rd_cmd),
        .rd_addr(acc_addr),
        .rd_data(data_out),
        .wr_be(mem_be),
        .wr_addr(wr_addr_reg),
        .wr_data(data_in)
    ); // [RULE_12]

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_mask_no_write: assert property (clk_gate_n |-> mem_be == '0) // [RULE_02] [RULE_20]
        else $error("write performed in masked cycle");
    a_mask_hold_pos: assert property (clk_gate_n && !sleep_request |=> $stable(pos_reg)) // [RULE_02]
        else $error("burst position moved in masked cycle");
    a_load_addr_cap: assert property (edge_en && load && selected
        |=> upper_reg == $past(addr[ADDR_W-1:`SP_BEAT_W]) && pos_reg.beat == `SP_BEAT_RST) // [RULE_03]
        else $error("address not captured on load");
    a_desel_load: assert property (edge_en && load && !selected |=> state_reg == ST_IDLE && !data_oe) // [RULE_04] [RULE_18]
        else $error("deselect load did not deselect");
    a_step_wraps: assert property (edge_en && !load ##1 edge_en && !load ##1 edge_en && !load
        ##1 edge_en && !load |=> pos_reg.beat == $past(pos_reg.beat, 4)) // [RULE_05] [RULE_19]
        else $error("burst counter did not wrap after four beats");
    a_load_kind: assert property (edge_en && load && selected
        |=> state_reg == ($past(rd_wr_sel) ? ST_READ : ST_WRITE)) // [RULE_06]
        else $error("wrong operation started on load");
    a_lane_strobe: assert property (edge_en && wr_beat && !(&lane_write_strobe_n) ##1 edge_en
        |-> mem_be == ~$past(lane_write_strobe_n)) // [RULE_07] [RULE_17]
        else $error("lane strobes not applied one cycle later");
    a_oe_release: assert property (out_enable_n || sleep_request |-> !data_oe) // [RULE_08] [RULE_13]
        else $error("data driven with output enable inactive");
    a_interleave: assert property (burst_order_sel && edge_en && !load && state_reg != ST_IDLE // [RULE_10]
        |=> (cur_low ^ pos_reg.start) == $past(cur_low ^ pos_reg.start) + `SP_BEAT_STEP
        && $stable(pos_reg.start))
        else $error("interleaved sequence wrong");
    a_linear_seq: assert property (!burst_order_sel && edge_en && !load && state_reg != ST_IDLE
        |=> cur_low == $past(cur_low) + `SP_BEAT_STEP) // [RULE_11]
        else $error("linear sequence wrong");
    a_sleep_idle: assert property (sleep_request |=> state_reg == ST_IDLE && !wr_pend_reg.valid
        && sleep_active) // [RULE_12] [RULE_13] [RULE_14]
        else $error("not idle in sleep");
    a_upper_hold: assert property (edge_en && !load |=> $stable(upper_reg)) // [RULE_21]
        else $error("upper address changed during burst");
    a_mask_hold_out: assert property (clk_gate_n && !sleep_request // [RULE_20]
        |=> $stable(data_out) && $stable(drive_reg))
        else $error("read data or drive moved in masked cycle");
    a_read_drive: assert property (edge_en && load && selected && rd_wr_sel // [RULE_06] [RULE_08]
        |=> drive_reg)
        else $error("read load did not drive the bus");

endmodule : flowthrough_burst_sram_port

`default_nettype wire

/* File: rtl/sram_port_pkg.sv */
`include "sram_port_regs.svh"

package sram_port_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = `SP_ST_IDLE,
        ST_READ = `SP_ST_READ,
        ST_WRITE = `SP_ST_WRITE
    } op_state_type;

    typedef struct packed {
        logic valid;
        logic [`SP_LANES-1:0] lane_we;
    } wr_pend_type;

    typedef struct packed {
        logic [`SP_BEAT_W-1:0] start;
        logic [`SP_BEAT_W-1:0] beat;
    } burst_pos_type;

endpackage : sram_port_pkg

/* File: rtl/sram_port_regs.svh */
`ifndef SRAM_PORT_REGS_SVH
`define SRAM_PORT_REGS_SVH

`define SP_LANES 4
`define SP_LANE_W 8
`define SP_BEAT_W 2
`define SP_ADDR_W 20
`define SP_BEAT_RST 2'h0
`define SP_BEAT_STEP 2'h1
`define SP_LANES_OFF 4'hf
`define SP_ST_IDLE 2'h0
`define SP_ST_READ 2'h1
`define SP_ST_WRITE 2'h3

`endif

/* File: rtl/sram_store.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sram_port_regs.svh"

module sram_store #(
    parameter int ADDR_W = `SP_ADDR_W,
    parameter int LANES = `SP_LANES,
    parameter int LANE_W = `SP_LANE_W
) (
    input wire logic clk,
    input wire logic rd_en,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [LANES*LANE_W-1:0] rd_data,
    input wire logic [LANES-1:0] wr_be,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [LANES*LANE_W-1:0] wr_data
);

    logic [LANES*LANE_W-1:0] mem [0:(1<<ADDR_W)-1];

    // Contents are never cleared so data survive reset and sleep
    always_ff @(posedge clk) begin
        for (int i = 0; i < LANES; i++) begin
            if (wr_be[i]) begin
                mem[wr_addr][i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
            end
        end
    end

    // Same-address write in the read cycle is forwarded lane by lane
    always_ff @(posedge clk) begin
        if (rd_en) begin
            for (int i = 0; i < LANES; i++) begin
                if (wr_be[i] && (wr_addr == rd_addr)) begin
                    rd_data[i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
                end else begin
                    rd_data[i*LANE_W +: LANE_W] <= mem[rd_addr][i*LANE_W +: LANE_W];
                end
            end
        end
    end

endmodule : sram_store

`default_nettype wire
